// *** src/adc_config_register_bank.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Sixteen-bit first custom code register at 0x26, used by both custom patterns.
// - Bit zero of the first custom code is the output LSB.
// - Single custom pattern drives the first custom code constantly.
// - Polarity register bits 3:0 swap inputs per channel in quad setup.
// - Polarity register bits 5:4 swap inputs per channel in dual setup.
// - Polarity register bit 6 swaps input of the single channel.
// - All polarity swap bits clear after reset.
// - Power register holds quad, dual and single sleep bits, inactive after reset.
// - Power register bits 11:10 select power-down pin function, power-down default.
// - Soft reset bit restores all registers to defaults, then self-clears.
// - Serial word is 8 address bits then 16 data bits, loaded into register.
// - Dual custom pattern alternates first and second custom codes.
module adc_config_register_bank (
    input  wire logic        i_clk,                      // Serial clock
    input  wire logic        i_reset_pin_n,                   // Reset pin, active low
    input  wire logic        i_csn,                      // Chip select, active low
    input  wire logic        i_sdata,                    // Serial data
    input  wire logic        i_sample_en,                // Sample strobe, same domain
    input  wire logic [15:0] i_sample,                   // Converted sample
    output logic [3:0]       o_quad_channel_doze_bits,   // Quad sleep
    output logic [1:0]       o_dual_channel_doze_bits,   // Dual sleep
    output logic             o_single_channel_doze_bit,  // Single sleep
    output logic             o_sleep,                    // Chip sleep
    output logic             o_power_down_bit,           // Chip power-down
    output logic [1:0]       o_powerdown_pin_function,   // PD pin function
    output logic [15:0]      o_drive_cfg,                // LVDS drive
    output logic [15:0]      o_term_cfg,                 // LVDS termination
    output logic [3:0]       o_quad_polarity_swap,       // Quad swap
    output logic [1:0]       o_dual_polarity_swap,       // Dual swap
    output logic             o_single_polarity_swap,     // Single swap
    output logic [15:0]      o_data_out                  // Output data word
);
    typedef struct packed {
        logic [15:0] power;
        logic [15:0] drive;
        logic [15:0] term;
        logic [15:0] polarity;
        logic [15:0] pattern;
        logic [15:0] code1;
        logic [15:0] code2;
        logic        toggle;
        logic [15:0] ramp;
        logic [15:0] dout;
    } bank_s;

    bank_s       st_ff;
    bank_s       nxt_st;
    logic        sdata_m_ff;
    logic        sdata_s_ff;
    logic        csn_m_ff;
    logic        csn_s_ff;
    logic        wr_valid;
    logic [23:0] wr_word;
    logic [7:0]  wr_addr;
    logic [15:0] wr_data;

    ////////////////////////////////////////////////////////////////////////
    // Pins are resynchronised even though this block runs on the serial clock
    always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
        if (!i_reset_pin_n) begin
            sdata_m_ff <= 1'b0;
            sdata_s_ff <= 1'b0;
            csn_m_ff   <= 1'b1;
            csn_s_ff   <= 1'b1;
        end else begin
            sdata_m_ff <= i_sdata;
            sdata_s_ff <= sdata_m_ff;
            csn_m_ff   <= i_csn;
            csn_s_ff   <= csn_m_ff;
        end
    end

    serial_word_shifter u_shift (
        .i_clk    (i_clk),
        .i_reset_pin_n (i_reset_pin_n),
        .i_csn    (csn_s_ff),
        .i_sdata  (sdata_s_ff),
        .o_valid  (wr_valid),
        .o_word   (wr_word)
    );

    // Address leads, data follows
    assign wr_addr = wr_word[23:16];
    assign wr_data = wr_word[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Register writes, soft reset and pattern generator
    always_comb begin
        nxt_st = st_ff;
        if (wr_valid) begin
            case (wr_addr)
                adc_cfg_pkg::ADDR_SOFT_RESET: begin
                    // Soft reset bit is never stored, so it reads as self-cleared
                    if (wr_data[adc_cfg_pkg::SOFT_RESET_BIT]) begin
                        nxt_st.power    = adc_cfg_pkg::RST_POWER;
                        nxt_st.drive    = adc_cfg_pkg::RST_DRIVE;
                        nxt_st.term     = adc_cfg_pkg::RST_TERM;
                        nxt_st.polarity = adc_cfg_pkg::RST_POLARITY;
                        nxt_st.pattern  = adc_cfg_pkg::RST_PATTERN;
                        nxt_st.code1    = adc_cfg_pkg::RST_CODE;
                        nxt_st.code2    = adc_cfg_pkg::RST_CODE;
                    end
                end
                adc_cfg_pkg::ADDR_POWER:    nxt_st.power    = wr_data & adc_cfg_pkg::MASK_POWER;
                adc_cfg_pkg::ADDR_DRIVE:    nxt_st.drive    = wr_data & adc_cfg_pkg::MASK_DRIVE;
                adc_cfg_pkg::ADDR_TERM:     nxt_st.term     = wr_data & adc_cfg_pkg::MASK_TERM;
                adc_cfg_pkg::ADDR_POLARITY: nxt_st.polarity = wr_data & adc_cfg_pkg::MASK_POLARITY;
                adc_cfg_pkg::ADDR_PATTERN:  nxt_st.pattern  = wr_data & adc_cfg_pkg::MASK_PATTERN;
                adc_cfg_pkg::ADDR_CODE1:    nxt_st.code1    = wr_data;
                adc_cfg_pkg::ADDR_CODE2:    nxt_st.code2    = wr_data;
                default: begin
                    // Addresses outside this bank are ignored
                end
            endcase
        end
        // Output word updates once per sample strobe
        if (i_sample_en) begin
            nxt_st.toggle = ~st_ff.toggle;
            nxt_st.ramp   = st_ff.ramp + 16'h0001;
            if (st_ff.pattern[adc_cfg_pkg::PAT_RAMP_BIT]) begin
                nxt_st.dout = st_ff.ramp;
            end else if (st_ff.pattern[adc_cfg_pkg::PAT_DUAL_BIT]) begin
                nxt_st.dout = st_ff.toggle ? st_ff.code2 : st_ff.code1;
            end else if (st_ff.pattern[adc_cfg_pkg::PAT_SINGLE_BIT]) begin
                nxt_st.dout = st_ff.code1;
            end else begin
                nxt_st.dout = i_sample;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
        if (!i_reset_pin_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode; every source is a bit of the registered state
    assign o_quad_channel_doze_bits  = st_ff.power[3:0];
    assign o_dual_channel_doze_bits  = st_ff.power[5:4];
    assign o_single_channel_doze_bit = st_ff.power[6];
    assign o_sleep                   = st_ff.power[8];
    assign o_power_down_bit          = st_ff.power[9];
    assign o_powerdown_pin_function  = st_ff.power[11:10];
    assign o_drive_cfg               = st_ff.drive;
    assign o_term_cfg                = st_ff.term;
    assign o_quad_polarity_swap      = st_ff.polarity[3:0];
    assign o_dual_polarity_swap      = st_ff.polarity[5:4];
    assign o_single_polarity_swap    = st_ff.polarity[6];
    assign o_data_out                = st_ff.dout;
endmodule // adc_config_register_bank

// *** src/adc_cfg_pkg.sv ***
package adc_cfg_pkg;
    // Register addresses (8-bit serial address field)
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0] ADDR_POWER      = 8'h0f;
    localparam logic [7:0] ADDR_DRIVE      = 8'h11;
    localparam logic [7:0] ADDR_TERM       = 8'h12;
    localparam logic [7:0] ADDR_POLARITY   = 8'h24;
    localparam logic [7:0] ADDR_PATTERN    = 8'h25;
    localparam logic [7:0] ADDR_CODE1      = 8'h26;
    localparam logic [7:0] ADDR_CODE2      = 8'h27;

    // Serial word layout
    localparam int WORD_BITS   = 24;
    localparam int ADDR_BITS   = 8;
    localparam int DATA_BITS   = 16;
    localparam logic [4:0] LAST_BIT = 5'h17;

    // Field positions
    localparam int SOFT_RESET_BIT = 0;
    localparam int PAT_RAMP_BIT   = 6;
    localparam int PAT_DUAL_BIT   = 5;
    localparam int PAT_SINGLE_BIT = 4;

    // Writable bit masks per register
    localparam logic [15:0] MASK_POWER    = 16'h0f7f;
    localparam logic [15:0] MASK_DRIVE    = 16'h07ff;
    localparam logic [15:0] MASK_TERM     = 16'h47ff;
    localparam logic [15:0] MASK_POLARITY = 16'h007f;
    localparam logic [15:0] MASK_PATTERN  = 16'h0070;

    // Reset values
    localparam logic [15:0] RST_POWER    = 16'h0000;
    localparam logic [15:0] RST_DRIVE    = 16'h0000;
    localparam logic [15:0] RST_TERM     = 16'h0000;
    localparam logic [15:0] RST_POLARITY = 16'h0000;
    localparam logic [15:0] RST_PATTERN  = 16'h0000;
    localparam logic [15:0] RST_CODE     = 16'h0000;
endpackage

// *** src/serial_word_shifter.sv ***
`timescale 1ns/1ps
// Collects one 24-bit word per select pulse; excess bits are dropped.
module serial_word_shifter (
    input  wire logic        i_clk,      // Serial clock
    input  wire logic        i_reset_pin_n,   // Async reset, active low
    input  wire logic        i_csn,      // Chip select, active low
    input  wire logic        i_sdata,    // Serial data
    output logic             o_valid,    // One-cycle word strobe
    output logic [23:0]      o_word      // Address and data word
);
    typedef struct packed {
        logic [4:0]  cnt;
        logic        done;
        logic [23:0] sh;
        logic        valid;
    } shift_s;

    shift_s st_ff;
    shift_s nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Shift on each rising edge while selected; stop after the first word
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        if (i_csn) begin
            nxt_st.cnt = 5'h00;
            nxt_st.done = 1'b0;
        end else if (!st_ff.done) begin
            nxt_st.sh = {st_ff.sh[22:0], i_sdata};
            if (st_ff.cnt == adc_cfg_pkg::LAST_BIT) begin
                nxt_st.valid = 1'b1;
                nxt_st.done = 1'b1;     // Extra bits ignored
            end else begin
                nxt_st.cnt = st_ff.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
        if (!i_reset_pin_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_valid = st_ff.valid;
    assign o_word  = st_ff.sh;
endmodule // serial_word_shifter

// *** verification/serial_host_model.sv ***
`timescale 1ns/1ps
// Host on the three-wire port: one word per select pulse
module serial_host_model (
    input  wire logic i_clk,   // Serial clock
    output logic      o_csn,   // Chip select, active low
    output logic      o_sdata  // Serial data
);
    initial begin
        o_csn = 1'b1;
        o_sdata = 1'b0;
    end
    // Address byte then data, MSB first; extra ones follow to probe the drop
    task automatic send(input logic [23:0] word, input int extra);
        for (int i = 0; i < 24 + extra; i++) begin
            @(posedge i_clk);
            o_csn <= 1'b0;
            o_sdata <= (i < 24) ? word[23 - i] : 1'b1;
        end
        @(posedge i_clk);
        o_csn <= 1'b1;
        o_sdata <= ~o_sdata; // Released line must not keep the last bit
        repeat (8) @(posedge i_clk); // Select high long enough for the sync flops
    endtask
endmodule // serial_host_model

// *** verification/adc_cfg_chk.sv ***
`timescale 1ns/1ps
module adc_cfg_chk (
    input wire logic        i_clk,                    // Serial clock
    input wire logic        i_reset_pin_n,                 // Reset, active low
    input wire logic        i_csn,                    // Chip select
    input wire logic        i_sample_en,              // Sample strobe
    input wire logic [3:0]  o_quad_channel_doze_bits, // Quad sleep
    input wire logic [1:0]  o_powerdown_pin_function, // Pin function
    input wire logic [15:0] o_drive_cfg,              // Drive
    input wire logic [15:0] o_term_cfg,               // Termination
    input wire logic [3:0]  o_quad_polarity_swap,     // Quad swap
    input wire logic [15:0] o_data_out                // Output word
);
    logic [3:0] quiet_ff; // Edges since select was low, saturating
    // Settings may only move shortly after a word, never out of the blue
    always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
        if (!i_reset_pin_n) quiet_ff <= 4'hf;
        else quiet_ff <= !i_csn ? 4'h0 : (quiet_ff == 4'hf ? 4'hf : quiet_ff + 4'h1);
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_pin_n);
    rst_pol_a: assert property ($rose(i_reset_pin_n) |-> o_quad_polarity_swap == 4'h0)
        else $error("polarity swap set after reset");
    rst_doze_a: assert property ($rose(i_reset_pin_n) |-> o_quad_channel_doze_bits == 4'h0)
        else $error("doze bits set after reset");
    rst_pin_a: assert property ($rose(i_reset_pin_n) |-> o_powerdown_pin_function == 2'h0)
        else $error("pin function not default after reset");
    pol_quiet_a: assert property ($changed(o_quad_polarity_swap) |-> quiet_ff < 4'h8)
        else $error("polarity moved without a word");
    doze_quiet_a: assert property ($changed(o_quad_channel_doze_bits) |-> quiet_ff < 4'h8)
        else $error("doze bits moved without a word");
    drv_mask_a: assert property ((o_drive_cfg & 16'hf800) == 16'h0000)
        else $error("drive bits outside mask");
    term_mask_a: assert property ((o_term_cfg & 16'hb800) == 16'h0000)
        else $error("termination bits outside mask");
    data_hold_a: assert property (!$past(i_sample_en) && quiet_ff == 4'hf |-> $stable(o_data_out))
        else $error("output word moved without a strobe");
    cover property ($changed(o_quad_polarity_swap));
    cover property (i_sample_en ##1 $changed(o_data_out));
    cover property ($fell(o_quad_channel_doze_bits[0]));
endmodule // adc_cfg_chk
bind adc_config_register_bank adc_cfg_chk chk (.i_clk, .i_reset_pin_n, .i_csn, .i_sample_en, .o_quad_channel_doze_bits,
    .o_powerdown_pin_function, .o_drive_cfg, .o_term_cfg, .o_quad_polarity_swap, .o_data_out);

// *** verification/adc_config_register_bank_tb.sv ***
`timescale 1ns/1ps
module adc_config_register_bank_tb;
    logic i_clk = 1'b0, i_reset_pin_n = 1'b0, i_csn, i_sdata, i_sample_en = 1'b0;
    logic [15:0] i_sample = 16'h0000, o_drive_cfg, o_term_cfg, o_data_out, q1, q2;
    logic [3:0] o_quad_channel_doze_bits, o_quad_polarity_swap;
    logic [1:0] o_dual_channel_doze_bits, o_powerdown_pin_function, o_dual_polarity_swap;
    logic o_single_channel_doze_bit, o_sleep, o_power_down_bit, o_single_polarity_swap;
    int mismatches = 0, total_checks = 0;
    wire [15:0] pwr = {4'h0, o_powerdown_pin_function, o_power_down_bit, o_sleep, 1'b0,
        o_single_channel_doze_bit, o_dual_channel_doze_bits, o_quad_channel_doze_bits};
    wire [15:0] pol = {9'h0, o_single_polarity_swap, o_dual_polarity_swap, o_quad_polarity_swap};
    always #4 i_clk = ~i_clk;
    serial_host_model host (.i_clk, .o_csn(i_csn), .o_sdata(i_sdata));
    adc_config_register_bank dut (.i_clk, .i_reset_pin_n, .i_csn, .i_sdata, .i_sample_en, .i_sample,
        .o_quad_channel_doze_bits, .o_dual_channel_doze_bits, .o_single_channel_doze_bit, .o_sleep,
        .o_power_down_bit, .o_powerdown_pin_function, .o_drive_cfg, .o_term_cfg, .o_quad_polarity_swap,
        .o_dual_polarity_swap, .o_single_polarity_swap, .o_data_out);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.send({a, d}, 0);
    endtask
    // One strobe; the word is read half a cycle after the edge that takes it
    task automatic strobe(input logic [15:0] s, output logic [15:0] q);
        @(posedge i_clk);
        i_sample_en <= 1'b1;
        i_sample <= s;
        @(posedge i_clk);
        i_sample_en <= 1'b0;
        @(negedge i_clk);
        q = o_data_out;
    endtask
    task automatic t_registers();
        chk("power", 16'h0000, pwr);
        chk("polarity", 16'h0000, pol);
        wr(adc_cfg_pkg::ADDR_POWER, 16'hffff);
        chk("power", 16'h0f7f, pwr);
        host.send({adc_cfg_pkg::ADDR_POLARITY, 16'h005a}, 6);
        chk("polarity", 16'h005a, pol);
        wr(adc_cfg_pkg::ADDR_DRIVE, 16'hffff);
        wr(adc_cfg_pkg::ADDR_TERM, 16'hffff);
        wr(8'h13, 16'h0000); // Unmapped: nothing may move
        chk("drive", 16'h07ff, o_drive_cfg);
        chk("term", 16'h47ff, o_term_cfg);
    endtask
    task automatic t_patterns();
        wr(adc_cfg_pkg::ADDR_CODE1, 16'h8001);
        wr(adc_cfg_pkg::ADDR_PATTERN, 16'h0010);
        strobe(16'h1234, q1);
        strobe(16'h5678, q2);
        chk("single a", 16'h8001, q1);
        chk("single b", 16'h8001, q2);
        wr(adc_cfg_pkg::ADDR_CODE2, 16'h00f0);
        wr(adc_cfg_pkg::ADDR_PATTERN, 16'h0020);
        strobe(16'h1234, q1);
        strobe(16'h1234, q2);
        chk("dual pair", 16'h80f1, q1 ^ q2);
        wr(adc_cfg_pkg::ADDR_PATTERN, 16'h0040);
        strobe(16'h1234, q1);
        strobe(16'h1234, q2);
        chk("ramp step", q1 + 16'h0001, q2);
        wr(adc_cfg_pkg::ADDR_PATTERN, 16'h0000);
        strobe(16'h1234, q1);
        chk("sample", 16'h1234, q1);
    endtask
    // Soft reset clears power and drive, then must not keep clearing later writes
    task automatic t_soft_reset();
        wr(adc_cfg_pkg::ADDR_SOFT_RESET, 16'h0001);
        chk("power", 16'h0000, pwr);
        chk("drive", 16'h0000, o_drive_cfg);
        wr(adc_cfg_pkg::ADDR_POLARITY, 16'h0025);
        chk("polarity", 16'h0025, pol);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #40000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset_pin_n <= 1'b1;
        @(negedge i_clk);
        t_registers();
        t_patterns();
        t_soft_reset();
        tally_and_finish();
    end
endmodule // adc_config_register_bank_tb
